// >>> shared/crlc_pkg.sv
package crlc_pkg;

    // ==========================================================
    // Register map (byte addresses on the AXI4-Lite slave)
    localparam logic [3:0] CRLC_ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] CRLC_ADDR_COMP_MODE = 4'h4;
    localparam logic [3:0] CRLC_ADDR_PORT_DIR  = 4'h8;
    localparam logic [3:0] CRLC_ADDR_STATUS    = 4'hc;

    // ==========================================================
    // Control register fields
    localparam int CRLC_POWER_BIT  = 7;
    localparam int CRLC_PIN_BIT    = 6;
    localparam int CRLC_RANGE_BIT  = 5;
    localparam int CRLC_SOURCE_BIT = 4;
    localparam int CRLC_TAP_MSB    = 3;
    localparam int CRLC_TAP_LSB    = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CRLC_CONTROL_RESET   = 8'h00;
    localparam logic [2:0] CRLC_COMP_MODE_RESET = 3'h7;
    localparam logic [7:0] CRLC_PORT_DIR_RESET  = 8'hff;

    // Comparator mode that routes the reference to both positive inputs
    localparam logic [2:0] CRLC_MODE_INTERNAL_REF = 3'h6;
    // Port bit shared with the reference output
    localparam int CRLC_SHARED_PIN_BIT = 2;

    // ==========================================================
    // Ladder level encoding: output = level_num / 96 of the source span
    localparam logic [6:0] CRLC_LOW_STEP   = 7'h04;
    localparam logic [6:0] CRLC_HIGH_STEP  = 7'h03;
    localparam logic [6:0] CRLC_HIGH_BASE  = 7'h18;

    // AXI responses
    localparam logic [1:0] CRLC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CRLC_RESP_SLVERR = 2'h2;

endpackage

// >>> core/crlc_ladder_ctrl.sv
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
// Contract
// - Control bit 7 set powers the ladder, clear powers it down.
// - Control bit 6 set routes the reference to the shared pin, clear disconnects it.
// - While bit 6 is set it overrides the port direction bit of the shared pin.
// - Range bit set gives output of tap times span over 24, from 0 to 0.625 of span.
// - Range bit clear gives a quarter span plus tap times span over 32, 0.250 to 0.719.
// - Source bit set selects the external reference pins, clear selects core rails.
// - The low four bits are an unsigned tap code 0..15 picking one of sixteen levels.
// - All control bits are read/write and read zero after power-on.
// - Device reset clears enable, pin drive, range and tap code.
// - Sleep wake-up by interrupt or watchdog leaves the control register intact.
// - The ladder works regardless of the comparator configuration.
// - The reference feeds both comparator positive inputs only in comparator mode 110.
module crlc_ladder_ctrl
    import crlc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // AXI4-Lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Sleep state (held, never resets the control register)
    input  wire logic        sleep_active,
    // Analog ladder controls
    output logic             ladder_power_enable,
    output logic             ladder_range_select,
    output logic             ladder_source_select,
    output logic [3:0]       ladder_tap_code,
    output logic [6:0]       ladder_output_level,
    // Shared port pin and comparator hookup
    output logic             ladder_pin_drive_enable,
    output logic             shared_pin_digital_oe,
    output logic             comparator_ref_connect
);

    // ==========================================================
    // Registers
    logic [7:0]  control_reg;
    logic [2:0]  comp_mode_reg;
    logic [7:0]  port_dir_reg;
    logic [3:0]  aw_addr_reg;
    logic        aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        w_held_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic        sleep_meta_reg;
    logic        sleep_sync_reg;
    logic [6:0]  level_reg;
    logic [6:0]  level_next;

    logic        do_write;
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ctl_sel;
    logic        wr_mode_sel;
    logic        wr_dir_sel;
    logic [1:0]  wr_resp;
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;
    logic [6:0]  low_level;
    logic [6:0]  high_level;
    logic        ctl_power;
    logic        ctl_pin;
    logic        ctl_range;
    logic        ctl_source;
    logic [3:0]  ctl_tap;

    function automatic logic addr_mapped(input logic [3:0] a);
        addr_mapped = (a == CRLC_ADDR_CONTROL) || (a == CRLC_ADDR_COMP_MODE) ||
                      (a == CRLC_ADDR_PORT_DIR) || (a == CRLC_ADDR_STATUS);
    endfunction

    // Status is read-only, so a write there is refused with an error
    function automatic logic addr_writable(input logic [3:0] a);
        addr_writable = addr_mapped(a) && (a != CRLC_ADDR_STATUS);
    endfunction

    // ==========================================================
    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
    assign do_write = (aw_held_reg || (s_axi_awvalid && s_axi_awready)) &&
                      (w_held_reg || (s_axi_wvalid && s_axi_wready));

    // Address side of a write: parked here until its data arrives
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
    end

    // Data side of a write: parked here until its address arrives
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end
    end

    // ==========================================================
    // Write decode: lane 0 carries every writable field; upper lanes
    // are ignored so a wide store from software cannot spill over
    assign wr_ctl_sel  = do_write && wr_strb[0] && addr_writable(wr_addr) && (wr_addr == CRLC_ADDR_CONTROL);
    assign wr_mode_sel = do_write && wr_strb[0] && addr_writable(wr_addr) && (wr_addr == CRLC_ADDR_COMP_MODE);
    assign wr_dir_sel  = do_write && wr_strb[0] && addr_writable(wr_addr) && (wr_addr == CRLC_ADDR_PORT_DIR);
    assign wr_resp     = addr_writable(wr_addr) ? CRLC_RESP_OKAY : CRLC_RESP_SLVERR;

    // Response waits for both halves; a master that never sends data
    // simply leaves the address parked

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= CRLC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_resp;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // ==========================================================
    // Register file; only the async reset clears it, sleep does not
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            control_reg <= CRLC_CONTROL_RESET;
        end else if (wr_ctl_sel) begin
            control_reg <= wr_data[7:0];
        end
    end

    // Comparator mode resets to its all-off code, not to zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            comp_mode_reg <= CRLC_COMP_MODE_RESET;
        end else if (wr_mode_sel) begin
            comp_mode_reg <= wr_data[2:0];
        end
    end

    // Direction resets to all inputs so no pin drives before software asks
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_dir_reg <= CRLC_PORT_DIR_RESET;
        end else if (wr_dir_sel) begin
            port_dir_reg <= wr_data[7:0];
        end
    end

    // Sleep only shown in status; sampling it never touches control_reg
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_meta_reg <= 1'b0;
            sleep_sync_reg <= 1'b0;
        end else begin
            sleep_meta_reg <= sleep_active;
            sleep_sync_reg <= sleep_meta_reg;
        end
    end

    // ==========================================================
    // Read channel: one-cycle answer
    assign s_axi_arready = !rvalid_reg;

    // Read mux kept out of the channel flops; the flops only capture it
    always_comb begin
        rd_resp = addr_mapped(s_axi_araddr) ? CRLC_RESP_OKAY : CRLC_RESP_SLVERR;
        case (s_axi_araddr)
            CRLC_ADDR_CONTROL:   rd_word = {24'h000000, control_reg};
            CRLC_ADDR_COMP_MODE: rd_word = {29'h0000000, comp_mode_reg};
            CRLC_ADDR_PORT_DIR:  rd_word = {24'h000000, port_dir_reg};
            CRLC_ADDR_STATUS:    rd_word = {22'h000000, sleep_sync_reg, comparator_ref_connect,
                                            shared_pin_digital_oe, level_reg};
            default:             rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= CRLC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_resp;
            rdata_reg  <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    // ==========================================================
    // Ladder outputs straight from the control register so that all
    // fields move on the write edge together
    assign ctl_power  = control_reg[CRLC_POWER_BIT];
    assign ctl_pin    = control_reg[CRLC_PIN_BIT];
    assign ctl_range  = control_reg[CRLC_RANGE_BIT];
    assign ctl_source = control_reg[CRLC_SOURCE_BIT];
    assign ctl_tap    = control_reg[CRLC_TAP_MSB:CRLC_TAP_LSB];

    assign ladder_power_enable     = ctl_power;
    assign ladder_pin_drive_enable = ctl_pin;
    assign ladder_range_select     = ctl_range;
    // Source only steers the analog supply mux; no digital logic uses it
    assign ladder_source_select    = ctl_source;
    assign ladder_tap_code         = ctl_tap;

    // ==========================================================
    // Level in 96ths of the span: /24 is 4/96, /32 is 3/96, 1/4 is 24/96.
    // Whole 96ths keep both ranges exact without a divider
    assign low_level  = 7'(CRLC_LOW_STEP * {3'h0, ctl_tap});
    assign high_level = 7'(CRLC_HIGH_BASE + CRLC_HIGH_STEP * {3'h0, ctl_tap});

    always_comb begin
        if (ctl_range) begin
            level_next = low_level;
        end else begin
            level_next = high_level;
        end
    end

    // Level reads zero while the ladder is powered down
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level_reg <= 7'h00;
        end else begin
            level_reg <= ctl_power ? level_next : 7'h00;
        end
    end

    assign ladder_output_level = level_reg;

    // ==========================================================
    // Shared pin and comparator hookup
    // Pin drive overrides the direction bit: the digital driver is off
    // whenever the reference owns the pin (direction 0 = output)
    assign shared_pin_digital_oe = !port_dir_reg[CRLC_SHARED_PIN_BIT] &&
                                   !ctl_pin;

    // Hookup depends on the mode alone, so the ladder can run with the
    // comparators off
    assign comparator_ref_connect = (comp_mode_reg == CRLC_MODE_INTERNAL_REF);

endmodule

// >>> tb/crlc_ladder_model.sv
`timescale 1ns/100ps
// ==========================================
// Resistor ladder: level in 96ths of the source span
module crlc_ladder_model (
    // Selection from the control block
    input  wire logic       power_on,
    input  wire logic       range_low,
    input  wire logic [3:0] tap,
    // Tap level
    output logic      [6:0] level_96
);
    always_comb begin
        if (!power_on) begin
            level_96 = 7'h00;
        end else if (range_low) begin
            level_96 = {1'b0, tap, 2'b00};
        end else begin
            level_96 = 7'h18 + 7'h03 * tap;
        end
    end
endmodule

// >>> tb/crlc_ladder_ctrl_chk.sv
`timescale 1ns/100ps
// ==========================================
// Port checks
module crlc_ladder_chk
    import crlc_pkg::*;
(
    // Clock, reset and write channels
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    // Ladder side
    input wire logic        ladder_power_enable,
    input wire logic        ladder_pin_drive_enable,
    input wire logic        ladder_range_select,
    input wire logic        ladder_source_select,
    input wire logic [3:0]  ladder_tap_code,
    input wire logic [6:0]  ladder_output_level,
    input wire logic        shared_pin_digital_oe,
    input wire logic        comparator_ref_connect
);
    logic [7:0] ctl;
    logic       aw_hs;
    logic       w_hs;
    logic       wr_ctl;
    logic       wr_mode;
    assign ctl = {ladder_power_enable, ladder_pin_drive_enable, ladder_range_select, ladder_source_select,
                  ladder_tap_code};
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign wr_ctl = aw_hs && w_hs && s_axi_wstrb[0] && s_axi_awaddr == CRLC_ADDR_CONTROL;
    assign wr_mode = aw_hs && w_hs && s_axi_wstrb[0] && s_axi_awaddr == CRLC_ADDR_COMP_MODE;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_power_pin; wr_ctl |=> ctl[7:6] == $past(s_axi_wdata[7:6]); endproperty
    a_power_pin: assert property (p_power_pin) else $error("power or pin bit not written");
    property p_fields; wr_ctl |=> ctl[5:0] == $past(s_axi_wdata[5:0]); endproperty
    a_fields: assert property (p_fields) else $error("range, source or tap not written");
    property p_hold; !aw_hs && !w_hs |=> $stable(ctl); endproperty
    a_hold: assert property (p_hold) else $error("control changed without a write");
    property p_pin_override; ladder_pin_drive_enable |-> !shared_pin_digital_oe; endproperty
    a_pin_override: assert property (p_pin_override) else $error("digital driver on while pin driven");
    property p_low; ladder_power_enable && ladder_range_select
        |=> ladder_output_level == {1'b0, $past(ladder_tap_code), 2'b00}; endproperty
    a_low: assert property (p_low) else $error("low range level wrong");
    property p_high; ladder_power_enable && !ladder_range_select
        |=> ladder_output_level == 7'h18 + 7'h03 * $past(ladder_tap_code); endproperty
    a_high: assert property (p_high) else $error("high range level wrong");
    property p_off; !ladder_power_enable |=> ladder_output_level == 7'h00; endproperty
    a_off: assert property (p_off) else $error("level present while powered down");
    property p_mode; wr_mode |=> comparator_ref_connect == ($past(s_axi_wdata[2:0]) == 3'h6); endproperty
    a_mode: assert property (p_mode) else $error("comparator hookup wrong for mode");
endmodule
bind crlc_ladder_ctrl crlc_ladder_chk chk_u (.*);

// >>> tb/tb_crlc_ladder_ctrl.sv
`timescale 1ns/100ps
module tb_crlc_ladder_ctrl
    import crlc_pkg::*;
;
    logic        mclk = 1'b0, rst_n = 1'b0, sleep_active = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0, ladder_tap_code;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        ladder_power_enable, ladder_range_select, ladder_source_select, ladder_pin_drive_enable;
    logic        shared_pin_digital_oe, comparator_ref_connect;
    logic [6:0]  ladder_output_level, model_level;
    logic [7:0]  vals [5] = '{8'hbf, 8'h80, 8'h8f, 8'h60, 8'hd5};
    int          num_errors = 0, tests_run = 0;
    wire  [7:0]  ctl_seen = {ladder_power_enable, ladder_pin_drive_enable, ladder_range_select,
                             ladder_source_select, ladder_tap_code};
    crlc_ladder_ctrl dut_u (.*);
    crlc_ladder_model ladder_u (.power_on(ladder_power_enable), .range_low(ladder_range_select),
                                .tap(ladder_tap_code), .level_96(model_level));
    always #2.5 mclk = ~mclk;
    // ==========================================
    // Checks and bus cycles
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Handshakes are judged at the falling edge so the comb readies are settled
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(negedge mclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge mclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) begin
                s_axi_bready <= 1'b0;
                chk("bresp", er, r);
                return;
            end
        end
        num_errors++;
        print_verdict();
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er = CRLC_RESP_OKAY);
        logic ar, r;
        logic [1:0] rr;
        logic [31:0] d;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(negedge mclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            d = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge mclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) begin
                s_axi_rready <= 1'b0;
                chk("rdata", e, d);
                chk("rresp", er, rr);
                return;
            end
        end
        num_errors++;
        print_verdict();
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        axi_rd(CRLC_ADDR_CONTROL, 32'h0);
        foreach (vals[i]) begin
            axi_wr(CRLC_ADDR_CONTROL, {24'ha5a5a5, vals[i]}, 4'hf, CRLC_RESP_OKAY);
            repeat (2) @(negedge mclk);
            chk("fields", vals[i], ctl_seen);
            chk("level", model_level, ladder_output_level);
            axi_rd(CRLC_ADDR_CONTROL, vals[i]);
        end
        axi_wr(CRLC_ADDR_PORT_DIR, 32'hfb, 4'h1, CRLC_RESP_OKAY);
        @(negedge mclk);
        chk("pin_oe_forced", 0, shared_pin_digital_oe);
        axi_wr(CRLC_ADDR_CONTROL, 32'h95, 4'h1, CRLC_RESP_OKAY);
        @(negedge mclk);
        chk("pin_oe_free", 1, shared_pin_digital_oe);
        for (int m = 0; m < 8; m++) begin
            axi_wr(CRLC_ADDR_COMP_MODE, m, 4'h1, CRLC_RESP_OKAY);
            @(negedge mclk);
            chk("ref_connect", m == 6, comparator_ref_connect);
        end
        axi_rd(CRLC_ADDR_STATUS, 32'ha7);
        axi_rd(4'h2, 32'h0, CRLC_RESP_SLVERR);
        axi_wr(CRLC_ADDR_STATUS, 32'h0, 4'h1, CRLC_RESP_SLVERR);
        axi_wr(CRLC_ADDR_CONTROL, 32'h15, 4'h1, CRLC_RESP_OKAY);
        axi_wr(CRLC_ADDR_CONTROL, 32'h0, 4'he, CRLC_RESP_OKAY);
        sleep_active <= 1'b1;
        repeat (8) @(posedge mclk);
        sleep_active <= 1'b0;
        axi_rd(CRLC_ADDR_CONTROL, 32'h15);
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        axi_rd(CRLC_ADDR_CONTROL, 32'h0);
        chk("level_after_reset", 0, ladder_output_level);
        print_verdict();
    end
endmodule
